/* File: rtl/wts_seq.sv */
// Transmitter status and housekeeping sequencer.
// Operation
// - Tone output squares at 4 kHz for 400 ms when transfer starts.
// - Level output is high for 400 ms when transfer starts.
// - Low external reset holds the sequencer in power-on reset with no transfer.
// - Internal power-on delay sequences startup without an outside supervisor.
// - Charge-complete end packet gives solid green and pauses transfer 5 s.
// - After that pause ping again; repeated charge-complete keeps indication.
// - Full charge-status packet shows done but keeps transfer running.
// - Overcurrent flags a fault and pauses transfer one minute.
// - Strapped supervisor is boot-loaded at first power-up, then joint.
// - Standby with supervisor raises and holds a sleep command after 100 ms idle.
// - Charge, fault and mode state are restored from the supervisor.
// - Over-temperature waits 5 minutes; internal or battery fault never retries.
`timescale 1ns/100ps
`include "wts_consts.svh"
module wts_seq
    import wts_pkg::*;
#(
    parameter int IND_CYC = `WTS_IND_CYC,
    parameter int HALF_CYC = `WTS_TONE_HALF,
    parameter longint CC_CYC = `WTS_CC_CYC,
    parameter longint OC_CYC = `WTS_OC_CYC,
    parameter longint OT_CYC = `WTS_OT_CYC,
    parameter int SLEEP_CYC = `WTS_SLEEP_CYC,
    parameter int BOOT_WORDS = `WTS_BOOT_WORDS,
    parameter int POR_CYC = `WTS_POR_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sup_strap,
    input wire logic sup_state_valid,
    input wire logic [1:0] sup_led_state,
    input wire logic sup_fault,
    input wire logic sup_trickle,
    input wire logic rx_present,
    input wire logic ept_valid,
    input wire logic [7:0] ept_code,
    input wire logic charge_status_full_packet,
    input wire logic overcurrent,
    input wire logic temp_shutdown,
    output logic power_enable,
    output logic ping,
    output logic tone_buzzer,
    output logic level_buzzer,
    output logic [1:0] led_state,
    output logic fault_flag,
    output logic trickle,
    output logic boot_valid,
    output logic [7:0] boot_addr,
    output logic sleep_cmd
);
    logic rs1_reg, rs2_reg;
    wts_state_e state_reg, state_next;
    // Long holds need more than 32 bits at the full clock rate.
    localparam int CW = `WTS_CNT_W;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [1:0] led_reg, led_next;
    logic fault_reg, fault_next;
    logic trk_reg, trk_next;
    logic sup_reg, sup_next;
    logic booted_reg, booted_next;
    logic [7:0] baddr_reg, baddr_next;
    logic ping_reg, ping_next;
    logic sleep_reg, sleep_next;
    logic start;

    // Reset release through two flip-flops.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rs1_reg <= 1'b0;
            rs2_reg <= 1'b0;
        end
        else
        begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end

    // Next-state logic; the registers follow in the block below.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        led_next = led_reg;
        fault_next = fault_reg;
        trk_next = trk_reg;
        sup_next = sup_reg;
        booted_next = booted_reg;
        baddr_next = baddr_reg;
        ping_next = 1'b0;
        sleep_next = 1'b0;
        start = 1'b0;
        unique case (state_reg)
            WTS_POR:
            begin
                if (cnt_reg >= CW'(POR_CYC - 1))
                begin
                    cnt_next = '0;
                    sup_next = sup_strap;
                    // Supervisor state is taken once, at wake-up.
                    if (sup_strap && sup_state_valid)
                    begin
                        led_next = sup_led_state;
                        fault_next = sup_fault;
                        trk_next = sup_trickle;
                    end
                    // A supervisor that holds state was loaded already.
                    if (sup_strap && !booted_reg && !sup_state_valid)
                    begin
                        state_next = WTS_BOOT;
                    end
                    else
                    begin
                        state_next = WTS_IDLE;
                    end
                end
                else
                begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            WTS_BOOT:
            begin
                // Boot strobes walk the word address up from zero.
                baddr_next = baddr_reg + 8'h01;
                if (baddr_reg == 8'(BOOT_WORDS - 1))
                begin
                    booted_next = 1'b1;
                    state_next = WTS_IDLE;
                end
            end
            WTS_IDLE:
            begin
                if (cnt_reg == '0)
                begin
                    ping_next = 1'b1;
                end
                if (rx_present)
                begin
                    start = 1'b1;
                    cnt_next = '0;
                    state_next = WTS_XFER;
                    if (led_reg != `WTS_LED_DONE)
                    begin
                        led_next = `WTS_LED_CHARGING;
                    end
                end
                else if (sup_reg && cnt_reg >= CW'(SLEEP_CYC - 1))
                begin
                    sleep_next = 1'b1;
                    state_next = WTS_SLEEP;
                end
                else
                begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            WTS_XFER:
            begin
                // Overcurrent outranks temperature, which outranks packets.
                if (overcurrent)
                begin
                    fault_next = 1'b1;
                    led_next = `WTS_LED_FAULT;
                    cnt_next = CW'(OC_CYC);
                    state_next = WTS_HOLD;
                end
                else if (temp_shutdown ||
                         (ept_valid && ept_code == `WTS_EPT_OT))
                begin
                    fault_next = 1'b1;
                    led_next = `WTS_LED_FAULT;
                    cnt_next = CW'(OT_CYC);
                    state_next = WTS_HOLD;
                end
                else if (ept_valid && (ept_code == `WTS_EPT_FAULT ||
                                       ept_code == `WTS_EPT_BATT))
                begin
                    fault_next = 1'b1;
                    led_next = `WTS_LED_FAULT;
                    state_next = WTS_LOCK;
                end
                else if (ept_valid && ept_code == `WTS_EPT_CC)
                begin
                    led_next = `WTS_LED_DONE;
                    cnt_next = CW'(CC_CYC);
                    state_next = WTS_HOLD;
                end
                else if (charge_status_full_packet)
                begin
                    led_next = `WTS_LED_DONE;
                    trk_next = 1'b1;
                end
                else if (!rx_present)
                begin
                    cnt_next = '0;
                    trk_next = 1'b0;
                    state_next = WTS_IDLE;
                end
            end
            WTS_HOLD:
            begin
                // Retry holds end with the fault cleared and a fresh ping.
                if (cnt_reg <= CW'(1))
                begin
                    cnt_next = '0;
                    fault_next = 1'b0;
                    state_next = WTS_IDLE;
                end
                else
                begin
                    cnt_next = cnt_reg - CW'(1);
                end
            end
            WTS_LOCK:
            begin
                // Fatal end packets park here until an external reset.
                state_next = WTS_LOCK;
            end
            // Sleep holds until the supervisor removes the supply.
            WTS_SLEEP:
            begin
                sleep_next = 1'b1;
            end
            // An illegal state code restarts the power-on sequence.
            default:
            begin
                cnt_next = '0;
                state_next = WTS_POR;
            end
        endcase
    end

    // A low ce freezes every register but the reset copy.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= WTS_POR;
            cnt_reg <= '0;
            led_reg <= `WTS_LED_OFF;
            fault_reg <= 1'b0;
            trk_reg <= 1'b0;
            sup_reg <= 1'b0;
            booted_reg <= 1'b0;
            baddr_reg <= 8'h00;
            ping_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end
        else if (!rs2_reg)
        begin
            state_reg <= WTS_POR;
            cnt_reg <= '0;
            ping_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            led_reg <= led_next;
            fault_reg <= fault_next;
            trk_reg <= trk_next;
            sup_reg <= sup_next;
            booted_reg <= booted_next;
            baddr_reg <= baddr_next;
            ping_reg <= ping_next;
            sleep_reg <= sleep_next;
        end
    end

    // The start strobe launches both buzzer outputs together.
    wts_buzzer #(
        .IND_CYC(IND_CYC),
        .HALF_CYC(HALF_CYC)
    ) u_buzzer (
        .clk(clk),
        .rst_n(rs2_reg),
        .ce(ce),
        .start(start),
        .tone(tone_buzzer),
        .level(level_buzzer)
    );

    // Status outputs are read straight from the registers.
    assign power_enable = (state_reg == WTS_XFER);
    assign ping = ping_reg;
    assign led_state = led_reg;
    assign fault_flag = fault_reg;
    assign trickle = trk_reg;
    assign boot_valid = (state_reg == WTS_BOOT);
    assign boot_addr = baddr_reg;
    assign sleep_cmd = sleep_reg;
endmodule

/* File: rtl/wts_consts.svh */
// Constants for the transmitter status sequencer.
`ifndef WTS_CONSTS_SVH
`define WTS_CONSTS_SVH
`define WTS_CLK_HZ 250000000
`define WTS_IND_MS 400
`define WTS_TONE_HZ 4000
`define WTS_CC_S 5
`define WTS_OC_S 60
`define WTS_OT_S 300
`define WTS_SLEEP_MS 100
`define WTS_BOOT_WORDS 64
`define WTS_POR_CYC 16
`define WTS_MS_CYC (`WTS_CLK_HZ / 1000)
`define WTS_IND_CYC (`WTS_IND_MS * `WTS_MS_CYC)
`define WTS_TONE_HALF (`WTS_CLK_HZ / (2 * `WTS_TONE_HZ))
`define WTS_CC_CYC (64'(`WTS_CC_S) * `WTS_CLK_HZ)
`define WTS_OC_CYC (64'(`WTS_OC_S) * `WTS_CLK_HZ)
`define WTS_OT_CYC (64'(`WTS_OT_S) * `WTS_CLK_HZ)
`define WTS_CNT_W 40
`define WTS_SLEEP_CYC (`WTS_SLEEP_MS * `WTS_MS_CYC)
`define WTS_EPT_CC 8'h01
`define WTS_EPT_FAULT 8'h02
`define WTS_EPT_OT 8'h03
`define WTS_EPT_BATT 8'h06
`define WTS_LED_OFF 2'h0
`define WTS_LED_CHARGING 2'h1
`define WTS_LED_DONE 2'h2
`define WTS_LED_FAULT 2'h3
`endif

/* File: rtl/wts_pkg.sv */
// Types for the transmitter status sequencer.
package wts_pkg;
    typedef enum logic [2:0] {
        WTS_POR, WTS_BOOT, WTS_IDLE, WTS_XFER, WTS_HOLD, WTS_LOCK, WTS_SLEEP
    } wts_state_e;
endpackage

/* File: rtl/wts_buzzer.sv */
// Start-of-transfer buzzer pulse generator.
`timescale 1ns/100ps
`include "wts_consts.svh"
module wts_buzzer
    import wts_pkg::*;
#(
    parameter int IND_CYC = `WTS_IND_CYC,
    parameter int HALF_CYC = `WTS_TONE_HALF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    output logic tone,
    output logic level
);
    logic [31:0] win_reg, win_next;
    logic [31:0] half_reg, half_next;
    logic tone_reg, tone_next;
    logic level_reg, level_next;

    always_comb
    begin
        win_next = win_reg;
        half_next = half_reg;
        tone_next = tone_reg;
        level_next = level_reg;
        if (start)
        begin
            win_next = 32'(IND_CYC);
            half_next = 32'(HALF_CYC - 1);
            tone_next = 1'b1;
            level_next = 1'b1;
        end
        else if (win_reg > 32'h00000001)
        begin
            win_next = win_reg - 32'h00000001;
            if (half_reg == 32'h00000000)
            begin
                half_next = 32'(HALF_CYC - 1);
                tone_next = ~tone_reg;
            end
            else
            begin
                half_next = half_reg - 32'h00000001;
            end
        end
        else
        begin
            win_next = 32'h00000000;
            tone_next = 1'b0;
            level_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_reg <= 32'h00000000;
            half_reg <= 32'h00000000;
            tone_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else if (ce)
        begin
            win_reg <= win_next;
            half_reg <= half_next;
            tone_reg <= tone_next;
            level_reg <= level_next;
        end
    end

    assign tone = tone_reg;
    assign level = level_reg;
endmodule

/* File: bench/wts_seq_props.sv */
// Port assertions for the transmitter status sequencer.
`timescale 1ns/100ps
`include "wts_consts.svh"
module wts_seq_props
    import wts_pkg::*;
#(
    parameter int IND_CYC = 40
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ept_valid,
    input wire logic [7:0] ept_code,
    input wire logic charge_status_full_packet,
    input wire logic overcurrent,
    input wire logic temp_shutdown,
    input wire logic power_enable,
    input wire logic tone_buzzer,
    input wire logic level_buzzer,
    input wire logic [1:0] led_state,
    input wire logic fault_flag,
    input wire logic trickle,
    input wire logic boot_valid,
    input wire logic [7:0] boot_addr,
    input wire logic sleep_cmd
);
    int lvl_reg;
    int lvl_next;
    logic quiet;
    assign quiet = !overcurrent && !temp_shutdown;
    always_comb
    begin
        lvl_next = level_buzzer ? lvl_reg + 1 : 0;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lvl_reg <= 0;
        else
            lvl_reg <= lvl_next;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    lvl_max_a: assert property
        (level_buzzer |-> lvl_reg < IND_CYC)
        else $error("Level buzzer held too long.");
    tone_hold_a: assert property
        ($rose(tone_buzzer) |-> tone_buzzer[*4])
        else $error("Tone half period too short.");
    buzz_rest_a: assert property
        (tone_buzzer |-> level_buzzer)
        else $error("Tone outside start window.");
    start_buzz_a: assert property
        ($rose(power_enable) |-> level_buzzer && tone_buzzer)
        else $error("No buzzer at transfer start.");
    rst_hold_a: assert property
        (disable iff (1'b0) !rst_n |=> !power_enable)
        else $error("Transfer during reset.");
    por_wait_a: assert property
        ($rose(rst_n) |-> !power_enable[*6])
        else $error("Transfer before startup delay.");
    cc_pause_a: assert property
        (ept_valid && ept_code == `WTS_EPT_CC && power_enable && quiet
        |=> (!power_enable && led_state == `WTS_LED_DONE)[*8])
        else $error("Charge complete not paused.");
    cs_keep_a: assert property
        (charge_status_full_packet && power_enable && !ept_valid && quiet
        |=> power_enable && trickle && led_state == `WTS_LED_DONE)
        else $error("Full charge status mishandled.");
    oc_halt_a: assert property
        (overcurrent && power_enable |=> (!power_enable && fault_flag)[*8])
        else $error("Overcurrent not halted.");
    fault_lock_a: assert property
        (ept_valid && power_enable && quiet && (ept_code == `WTS_EPT_FAULT
        || ept_code == `WTS_EPT_BATT) |=> !power_enable[*8])
        else $error("Fatal end packet retried.");
    boot_seq_a: assert property
        ($rose(boot_valid) |-> boot_addr == 8'h00 ##1 boot_addr == 8'h01)
        else $error("Boot addresses out of order.");
    sleep_off_a: assert property
        (sleep_cmd |-> !power_enable && !boot_valid)
        else $error("Sleep while active.");
    cover property ($rose(sleep_cmd));
    cover property ($fell(boot_valid));
    cover property (overcurrent && power_enable);
endmodule

/* File: bench/wts_sup_model.sv */
// Low-power supervisor model that cuts and restores the sequencer supply.
`timescale 1ns/100ps
module wts_sup_model
#(
    parameter int OFF_CYC = 20
)
(
    input wire logic clk,
    input wire logic sleep_cmd,
    input wire logic [1:0] led_state,
    input wire logic fault_flag,
    input wire logic trickle,
    output logic sup_rst_n,
    output logic sup_state_valid,
    output logic [1:0] sup_led_state,
    output logic sup_fault,
    output logic sup_trickle
);
    int off_cnt = 0;
    initial
    begin
        {sup_rst_n, sup_state_valid, sup_led_state} = 4'h8;
        {sup_fault, sup_trickle} = 2'h0;
    end
    always @(posedge clk)
    begin
        if (sleep_cmd && sup_rst_n)
        begin
            {sup_led_state, sup_fault, sup_trickle} <=
                {led_state, fault_flag, trickle};
            sup_state_valid <= 1'b1;
            sup_rst_n <= 1'b0;
            off_cnt <= OFF_CYC;
        end
        else if (off_cnt > 0)
            off_cnt <= off_cnt - 1;
        else
            sup_rst_n <= 1'b1;
    end
endmodule

/* File: bench/wts_seq_test.sv */
// Self-checking testbench for the transmitter status sequencer.
`timescale 1ns/100ps
`include "wts_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module wts_seq_test;
    import wts_pkg::*;
    localparam int IND = 40;
    localparam int CC = 50;
    localparam int OC = 60;
    localparam int OT = 70;
    localparam int BW = 8;
    logic clk = 0, tb_rst_n = 0, ce = 1, sup_strap = 1, rx_present = 0;
    logic ept_valid = 0, charge_status_full_packet = 0;
    logic overcurrent = 0, temp_shutdown = 0;
    logic [7:0] ept_code = 8'h00;
    logic rst_n, sup_rst_n, sup_state_valid, sup_fault, sup_trickle;
    logic [1:0] sup_led_state, led_state;
    logic power_enable, ping, tone_buzzer, level_buzzer, fault_flag, trickle;
    logic boot_valid, sleep_cmd;
    logic [7:0] boot_addr, a;
    int miscompares = 0, n_tests = 0, cyc = 0, n;
    assign rst_n = tb_rst_n & sup_rst_n;
    wts_seq #(.IND_CYC(IND), .HALF_CYC(4), .CC_CYC(CC), .OC_CYC(OC),
        .OT_CYC(OT), .SLEEP_CYC(30), .BOOT_WORDS(BW), .POR_CYC(4))
        u_dut (.*);
    wts_sup_model u_sup (.*);
    always #2 clk = ~clk;
    task step;
        @(posedge clk);
        #1;
    endtask
    task stop_test;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    task pkt(input logic [7:0] c);
        wait (power_enable === 1'b1);
        step();
        ept_code = c;
        ept_valid = 1;
        step();
        ept_valid = 0;
    endtask
    task t_boot;
        wait (boot_valid === 1'b1);
        #1;
        n = 0;
        while (boot_valid === 1'b1)
        begin
            a = boot_addr;
            step();
            n++;
        end
        `CHK(n, BW)
        `CHK(a, 8'(BW - 1))
        $display("boot done");
    endtask
    task t_start;
        rx_present = 1;
        wait (power_enable === 1'b1);
        #1;
        `CHK(tone_buzzer, 1'b1)
        n = 0;
        while (level_buzzer === 1'b1)
        begin
            step();
            n++;
        end
        `CHK(n >= IND - 1 && n <= IND, 1'b1)
        `CHK(tone_buzzer, 1'b0)
        charge_status_full_packet = 1;
        step();
        charge_status_full_packet = 0;
        `CHK({power_enable, trickle, led_state}, {2'h3, `WTS_LED_DONE})
        $display("start done");
    endtask
    task t_cc;
        pkt(`WTS_EPT_CC);
        `CHK({power_enable, led_state}, {1'b0, `WTS_LED_DONE})
        n = 0;
        while (ping !== 1'b1)
        begin
            step();
            n++;
        end
        `CHK(n >= CC - 1 && n <= CC + 5, 1'b1)
        pkt(`WTS_EPT_CC);
        `CHK(led_state, `WTS_LED_DONE)
        rx_present = 0;
        wait (sleep_cmd === 1'b1);
        wait (sup_rst_n === 1'b0);
        wait (sup_rst_n === 1'b1);
        wait (ping === 1'b1);
        step();
        step();
        `CHK(led_state, `WTS_LED_DONE)
        rx_present = 1;
        $display("charge done");
    endtask
    task t_pause(input logic oc, input int len);
        wait (power_enable === 1'b1);
        step();
        {overcurrent, temp_shutdown} = {oc, !oc};
        step();
        {overcurrent, temp_shutdown} = 2'h0;
        `CHK(power_enable, 1'b0)
        if (oc)
            `CHK(fault_flag, 1'b1)
        n = 0;
        while (power_enable !== 1'b1)
        begin
            step();
            n++;
        end
        `CHK(n >= len - 1 && n <= len + 20, 1'b1)
        $display("pause done");
    endtask
    task t_lock(input logic [7:0] c);
        pkt(c);
        repeat (OT + OC) step();
        `CHK(power_enable, 1'b0)
        tb_rst_n = 0;
        repeat (5) step();
        `CHK(power_enable, 1'b0)
        tb_rst_n = 1;
        $display("lock done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        tb_rst_n = 1;
        t_boot();
        t_start();
        t_cc();
        t_pause(1'b1, OC);
        t_pause(1'b0, OT);
        t_lock(`WTS_EPT_FAULT);
        t_lock(`WTS_EPT_BATT);
        stop_test();
    end
endmodule
bind wts_seq wts_seq_props #(.IND_CYC(IND_CYC)) u_props (.*);
